/* rtl/ufl_pkg.sv */
package ufl_pkg;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned FIFO_DEPTH = 4;
  localparam int unsigned LVL_W = 3;
  localparam int unsigned REG_W = 16;
  localparam int unsigned WB_W = 32;

  localparam logic [31:0] ADDR_TX_LEVEL = 32'h5000_1080;
  localparam logic [31:0] ADDR_RX_LEVEL = 32'h5000_1084;
  localparam logic [31:0] ADDR_SOFT_RST = 32'h5000_1088;
  localparam logic [31:0] ADDR_RTS_ALIAS = 32'h5000_108c;
  localparam logic [31:0] ADDR_BRK_ALIAS = 32'h5000_1090;
  localparam logic [31:0] ADDR_MODEM_CTRL = 32'h5000_10c0;
  localparam logic [31:0] ADDR_LINE_CTRL = 32'h5000_10c4;
  localparam logic [31:0] ADDR_FIFO_CTRL = 32'h5000_10c8;

  localparam int unsigned SRR_UR_BIT = 0;
  localparam int unsigned SRR_RFR_BIT = 1;
  localparam int unsigned SRR_XFR_BIT = 2;
  localparam int unsigned ALIAS_BIT = 0;
  localparam int unsigned MCR_RTS_BIT = 1;
  localparam int unsigned MCR_LOOP_BIT = 4;
  localparam int unsigned MCR_AFC_BIT = 5;
  localparam int unsigned MCR_SIR_BIT = 6;
  localparam int unsigned LCR_BRK_BIT = 6;
  localparam int unsigned FCR_EN_BIT = 0;
  localparam int unsigned FCR_RFR_BIT = 1;
  localparam int unsigned FCR_XFR_BIT = 2;
  localparam int unsigned FCR_TRIG_LO = 6;

  localparam logic RST_BIT = 1'b0;
  localparam logic [1:0] RST_TRIG = 2'h0;
  localparam logic AUTO_FLOW_OPTION = 1'b1;

  localparam logic [LVL_W-1:0] TRIG_ONE = 3'h1;
  localparam logic [LVL_W-1:0] TRIG_QUARTER = 3'h1;
  localparam logic [LVL_W-1:0] TRIG_HALF = 3'h2;
  localparam logic [LVL_W-1:0] TRIG_NEAR_FULL = 3'h2;

  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned SIR_PERIOD_NS = 1600;
  localparam int unsigned SIR_PULSE_NS = 150;
  localparam int unsigned SIR_PERIOD_CYC = SIR_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned SIR_PULSE_CYC =
    (SIR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SIR_CNT_W = 5;
endpackage : ufl_pkg

/* rtl/ufl_fifo.sv */
`timescale 1ns/1ps
module ufl_fifo #(
  parameter int unsigned W = 8,
  parameter int unsigned D = 4,
  parameter int unsigned AW = 2
) (
  // Clock and control
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic flush,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data,
  // Entry count
  output logic [AW:0] level
);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(D);
  logic [W-1:0] mem_q [D];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;

  assign in_ready = (cnt_q != FULL_CNT);
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  assign level = cnt_q;

  always_ff @(posedge clk) begin
    if (ce && push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  // Flush resets only pointers and count; stale words stay but are never read
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else if (ce) begin
      if (flush) begin
        wr_q <= '0;
        rd_q <= '0;
        cnt_q <= '0;
      end else begin
        if (push) begin
          wr_q <= wr_q + 1'b1;
        end
        if (pop) begin
          rd_q <= rd_q + 1'b1;
        end
        if (push && !pop) begin
          cnt_q <= cnt_q + 1'b1;
        end else if (pop && !push) begin
          cnt_q <= cnt_q - 1'b1;
        end
      end
    end
  end
endmodule : ufl_fifo

/* rtl/ufl_rst_sync.sv */
`timescale 1ns/1ps
module ufl_rst_sync (
  // Clock
  input wire logic clk,
  input wire logic ce,
  // Reset request and synchronised reset
  input wire logic arst_req,
  output logic rst_o
);
  logic [1:0] stage_q;

  // Asserts without a clock, releases after two enabled edges
  always_ff @(posedge clk or posedge arst_req) begin
    if (arst_req) begin
      stage_q <= 2'h3;
    end else if (ce) begin
      stage_q <= {stage_q[0], 1'b0};
    end
  end

  assign rst_o = stage_q[1];
endmodule : ufl_rst_sync

/* rtl/ufl_regs.sv */
`timescale 1ns/1ps
module ufl_regs (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Transmit FIFO: filled by bus side, drained by shifter
  input wire logic tx_in_valid,
  output logic tx_in_ready,
  input wire logic [7:0] tx_in_data,
  output logic tx_out_valid,
  input wire logic tx_out_ready,
  output logic [7:0] tx_out_data,
  // Receive FIFO: filled by receiver, drained by bus side
  input wire logic rx_in_valid,
  output logic rx_in_ready,
  input wire logic [7:0] rx_in_data,
  output logic rx_out_valid,
  input wire logic rx_out_ready,
  output logic [7:0] rx_out_data,
  // Core serial signals
  input wire logic core_sout,
  input wire logic core_sir_out_n,
  // Serial pins
  output logic sout,
  output logic sir_out_n,
  output logic rts_n,
  // Internal loopback and controller reset
  output logic loop_rts,
  output logic loop_break,
  output logic ctrl_rst
);
  logic ack_q;
  logic [31:0] dat_q;
  logic rts_q;
  logic loop_q;
  logic afc_q;
  logic sir_q;
  logic brk_q;
  logic fifo_en_q;
  logic [1:0] trig_q;
  logic tx_flush_q;
  logic rx_flush_q;
  logic srst_q;
  logic rts_n_q;
  logic sout_q;
  logic sir_n_q;
  logic [4:0] sir_cnt_q;
  logic [2:0] tx_level;
  logic [2:0] rx_level;
  logic soft_rst;
  logic [2:0] rx_thr;

  // Bus decode
  wire req = wb_cyc_i & wb_stb_i;
  wire first = req & ~ack_q;
  wire wr_acc = ce & ack_q & req & wb_we_i & wb_sel_i[0];
  wire hit_tfl = (wb_adr_i == ufl_pkg::ADDR_TX_LEVEL);
  wire hit_rfl = (wb_adr_i == ufl_pkg::ADDR_RX_LEVEL);
  wire hit_srr = (wb_adr_i == ufl_pkg::ADDR_SOFT_RST);
  wire hit_srts = (wb_adr_i == ufl_pkg::ADDR_RTS_ALIAS);
  wire hit_sbcr = (wb_adr_i == ufl_pkg::ADDR_BRK_ALIAS);
  wire hit_mcr = (wb_adr_i == ufl_pkg::ADDR_MODEM_CTRL);
  wire hit_lcr = (wb_adr_i == ufl_pkg::ADDR_LINE_CTRL);
  wire hit_fcr = (wb_adr_i == ufl_pkg::ADDR_FIFO_CTRL);
  wire wr_srr = wr_acc & hit_srr;
  wire wr_srts = wr_acc & hit_srts;
  wire wr_sbcr = wr_acc & hit_sbcr;
  wire wr_mcr = wr_acc & hit_mcr;
  wire wr_lcr = wr_acc & hit_lcr;
  wire wr_fcr = wr_acc & hit_fcr;
  wire [31:0] wd = wb_dat_i;

  // Clearing the FIFO enable resets both FIFOs
  wire fifo_off = wr_fcr & fifo_en_q & ~wd[ufl_pkg::FCR_EN_BIT];
  wire tx_flush_d = (wr_srr & wd[ufl_pkg::SRR_XFR_BIT])
    | (wr_fcr & wd[ufl_pkg::FCR_XFR_BIT]) | fifo_off;
  wire rx_flush_d = (wr_srr & wd[ufl_pkg::SRR_RFR_BIT])
    | (wr_fcr & wd[ufl_pkg::FCR_RFR_BIT]) | fifo_off;

  // Read mux; unmapped addresses and reserved bits read zero
  wire [15:0] mcr_rd = {9'h0, sir_q, afc_q, loop_q, 2'h0, rts_q, 1'b0};
  wire [15:0] lcr_rd = {9'h0, brk_q, 6'h0};
  wire [15:0] fcr_rd = {8'h0, trig_q, 5'h0, fifo_en_q};
  wire [15:0] rd_mux =
    hit_tfl ? {13'h0, tx_level} :
    hit_rfl ? {13'h0, rx_level} :
    hit_srts ? {15'h0, rts_q} :
    hit_sbcr ? {15'h0, brk_q} :
    hit_mcr ? mcr_rd :
    hit_lcr ? lcr_rd :
    hit_fcr ? fcr_rd : 16'h0;

  always_ff @(posedge clk) begin
    if (rst) begin
      ack_q <= 1'b0;
    end else if (ce) begin
      ack_q <= first;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      dat_q <= 32'h0;
    end else if (ce && first) begin
      dat_q <= {16'h0, rd_mux};
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // Reset request pulse: bus reset only, so it clears even during soft reset
  always_ff @(posedge clk) begin
    if (rst) begin
      srst_q <= 1'b0;
    end else if (ce) begin
      srst_q <= wr_srr & wd[ufl_pkg::SRR_UR_BIT];
    end
  end

  ufl_rst_sync u_rst_sync (
    .clk(clk),
    .ce(ce),
    .arst_req(srst_q),
    .rst_o(soft_rst)
  );

  // One reset for all but the bus ack, read data and reset request; a serial domain would take it too
  assign ctrl_rst = rst | soft_rst;

  // Shared storage: both aliases and full registers write the same flops
  always_ff @(posedge clk) begin
    if (ctrl_rst) begin
      rts_q <= ufl_pkg::RST_BIT;
      brk_q <= ufl_pkg::RST_BIT;
    end else if (ce) begin
      if (wr_mcr) begin
        rts_q <= wd[ufl_pkg::MCR_RTS_BIT];
      end else if (wr_srts) begin
        rts_q <= wd[ufl_pkg::ALIAS_BIT];
      end
      if (wr_lcr) begin
        brk_q <= wd[ufl_pkg::LCR_BRK_BIT];
      end else if (wr_sbcr) begin
        brk_q <= wd[ufl_pkg::ALIAS_BIT];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (ctrl_rst) begin
      loop_q <= ufl_pkg::RST_BIT;
      afc_q <= ufl_pkg::RST_BIT;
      sir_q <= ufl_pkg::RST_BIT;
    end else if (ce && wr_mcr) begin
      loop_q <= wd[ufl_pkg::MCR_LOOP_BIT];
      afc_q <= wd[ufl_pkg::MCR_AFC_BIT];
      sir_q <= wd[ufl_pkg::MCR_SIR_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (ctrl_rst) begin
      fifo_en_q <= ufl_pkg::RST_BIT;
      trig_q <= ufl_pkg::RST_TRIG;
    end else if (ce && wr_fcr) begin
      fifo_en_q <= wd[ufl_pkg::FCR_EN_BIT];
      trig_q <= wd[ufl_pkg::FCR_TRIG_LO+1:ufl_pkg::FCR_TRIG_LO];
    end
  end

  // Flush strobes last one enabled cycle, so software never clears them
  always_ff @(posedge clk) begin
    if (ctrl_rst) begin
      tx_flush_q <= 1'b0;
      rx_flush_q <= 1'b0;
    end else if (ce) begin
      tx_flush_q <= tx_flush_d;
      rx_flush_q <= rx_flush_d;
    end
  end

  ufl_fifo #(
    .W(ufl_pkg::DATA_W),
    .D(ufl_pkg::FIFO_DEPTH),
    .AW(ufl_pkg::LVL_W-1)
  ) u_tx_fifo (
    .clk(clk),
    .rst(ctrl_rst),
    .ce(ce),
    .flush(tx_flush_q),
    .in_valid(tx_in_valid),
    .in_ready(tx_in_ready),
    .in_data(tx_in_data),
    .out_valid(tx_out_valid),
    .out_ready(tx_out_ready),
    .out_data(tx_out_data),
    .level(tx_level)
  );

  ufl_fifo #(
    .W(ufl_pkg::DATA_W),
    .D(ufl_pkg::FIFO_DEPTH),
    .AW(ufl_pkg::LVL_W-1)
  ) u_rx_fifo (
    .clk(clk),
    .rst(ctrl_rst),
    .ce(ce),
    .flush(rx_flush_q),
    .in_valid(rx_in_valid),
    .in_ready(rx_in_ready),
    .in_data(rx_in_data),
    .out_valid(rx_out_valid),
    .out_ready(rx_out_ready),
    .out_data(rx_out_data),
    .level(rx_level)
  );

  // Receive trigger threshold
  assign rx_thr =
    (trig_q == 2'h0) ? ufl_pkg::TRIG_ONE :
    (trig_q == 2'h1) ? ufl_pkg::TRIG_QUARTER :
    (trig_q == 2'h2) ? ufl_pkg::TRIG_HALF : ufl_pkg::TRIG_NEAR_FULL;

  wire afc_act = ufl_pkg::AUTO_FLOW_OPTION & afc_q & fifo_en_q;
  wire rx_above = (rx_level >= rx_thr);
  wire rts_n_d = loop_q | ~rts_q | (afc_act & rx_above);
  wire sout_d = loop_q | (~brk_q & core_sout);
  wire sir_brk = sir_q & brk_q;
  wire sir_low = (sir_cnt_q < 5'(ufl_pkg::SIR_PULSE_CYC));
  wire sir_n_d = loop_q | (sir_brk ? ~sir_low : (~sir_q | core_sir_out_n));
  wire sir_wrap = (sir_cnt_q == 5'(ufl_pkg::SIR_PERIOD_CYC - 1));

  // Free-running pulse train while break is held in infrared mode
  always_ff @(posedge clk) begin
    if (ctrl_rst) begin
      sir_cnt_q <= 5'h0;
    end else if (ce) begin
      if (!sir_brk || sir_wrap) begin
        sir_cnt_q <= 5'h0;
      end else begin
        sir_cnt_q <= sir_cnt_q + 5'h1;
      end
    end
  end

  // Pins leave idle (high) from reset onward
  always_ff @(posedge clk) begin
    if (ctrl_rst) begin
      rts_n_q <= 1'b1;
      sout_q <= 1'b1;
      sir_n_q <= 1'b1;
    end else if (ce) begin
      rts_n_q <= rts_n_d;
      sout_q <= sout_d;
      sir_n_q <= sir_n_d;
    end
  end

  assign rts_n = rts_n_q;
  assign sout = sout_q;
  assign sir_out_n = sir_n_q;
  assign loop_rts = loop_q & rts_q;
  assign loop_break = loop_q & brk_q;

  property p_tx_level;
    @(posedge clk) disable iff (rst)
    (ce && first && !wb_we_i && hit_tfl) |=> (wb_dat_o == {29'h0, $past(tx_level)});
  endproperty
  a_tx_level: assert property (p_tx_level) else $error("tx level readback wrong");

  property p_rx_level;
    @(posedge clk) disable iff (rst)
    (ce && first && !wb_we_i && hit_rfl) |=> (wb_dat_o == {29'h0, $past(rx_level)});
  endproperty
  a_rx_level: assert property (p_rx_level) else $error("rx level readback wrong");

  property p_tx_flush;
    @(posedge clk) disable iff (ctrl_rst)
    (ce && wr_srr && wd[2]) |=> tx_flush_q ##1 (!ce || tx_level == 3'h0);
  endproperty
  a_tx_flush: assert property (p_tx_flush) else $error("tx flush did not empty");

  property p_rx_flush;
    @(posedge clk) disable iff (ctrl_rst)
    (ce && wr_srr && wd[1]) |=> rx_flush_q ##1 (!ce || rx_level == 3'h0);
  endproperty
  a_rx_flush: assert property (p_rx_flush) else $error("rx flush did not empty");

  property p_self_clear;
    @(posedge clk) disable iff (ctrl_rst)
    (ce && tx_flush_q && !tx_flush_d) |=> !tx_flush_q;
  endproperty
  a_self_clear: assert property (p_self_clear) else $error("flush bit stuck");

  property p_soft_rst;
    @(posedge clk) disable iff (rst)
    (ce && wr_srr && wd[0]) |=> (srst_q && ctrl_rst) ##1 ctrl_rst;
  endproperty
  a_soft_rst: assert property (p_soft_rst) else $error("soft reset not held");

  property p_rts_plain;
    @(posedge clk) disable iff (ctrl_rst)
    (ce && !loop_q && !afc_act) |=> (rts_n == !$past(rts_q));
  endproperty
  a_rts_plain: assert property (p_rts_plain) else $error("rts_n not following bit");

  property p_rts_auto;
    @(posedge clk) disable iff (ctrl_rst)
    (ce && afc_act && rx_above) |=> rts_n;
  endproperty
  a_rts_auto: assert property (p_rts_auto) else $error("rts_n low above trigger");

  property p_loop;
    @(posedge clk) disable iff (ctrl_rst)
    (ce && loop_q) |=> (rts_n && sout);
  endproperty
  a_loop: assert property (p_loop) else $error("pins active in loopback");

  property p_break;
    @(posedge clk) disable iff (ctrl_rst)
    (ce && brk_q && !loop_q) |=> !sout;
  endproperty
  a_break: assert property (p_break) else $error("break not driven");
endmodule : ufl_regs

/* verification/ufl_modem.sv */
`timescale 1ns/1ps
module ufl_modem (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bench control
  input wire logic drain_en,
  input wire logic send,
  input wire logic [7:0] send_data,
  // Design side
  input wire logic rts_n,
  input wire logic tx_out_valid,
  input wire logic [7:0] tx_out_data,
  output logic tx_out_ready,
  input wire logic rx_in_ready,
  output logic rx_in_valid,
  output logic [7:0] rx_in_data
);
  logic pend_q;
  logic [7:0] last_q;
  // Drain stalls for as long as the bench holds drain_en low
  assign tx_out_ready = drain_en;
  always_ff @(posedge clk) begin
    if (rst) begin
      pend_q <= 1'b0;
      rx_in_valid <= 1'b0;
      rx_in_data <= 8'h00;
      last_q <= 8'h00;
    end else begin
      if (tx_out_valid && tx_out_ready) begin
        last_q <= tx_out_data;
      end
      if (send) begin
        pend_q <= 1'b1;
        rx_in_data <= send_data;
      end
      // Idle data is inverted so a stale byte never looks valid
      if (rx_in_valid && rx_in_ready) begin
        rx_in_valid <= 1'b0;
        pend_q <= 1'b0;
        rx_in_data <= ~rx_in_data;
      end else if (pend_q && !rts_n && !rx_in_valid) begin
        rx_in_valid <= 1'b1;
      end
    end
  end
endmodule : ufl_modem

/* verification/uart_fifo_level_and_shadow_regs_tb.sv */
`timescale 1ns/1ps
module uart_fifo_level_and_shadow_regs_tb;
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [31:0] wb_adr_i = 32'h0, wb_dat_i = 32'h0, wb_dat_o;
  logic [3:0] wb_sel_i = 4'h0;
  logic wb_ack_o, tx_in_valid = 1'b0, tx_in_ready, tx_out_valid, tx_out_ready;
  logic rx_in_valid, rx_in_ready, rx_out_valid, rx_out_ready = 1'b0;
  logic [7:0] tx_in_data = 8'h00, tx_out_data, rx_in_data, rx_out_data;
  logic [7:0] r_q = 8'h61, send_data = 8'h00, pd = 8'h00;
  logic core_sout = 1'b1, core_sir_out_n = 1'b1, sout, sir_out_n, rts_n;
  logic loop_rts, loop_break, ctrl_rst, drain_en = 1'b0, send = 1'b0, ok;
  int err_total = 0, compares = 0, i, k, c, n;
  logic [31:0] al [6];

  ufl_regs u_dut (.clk, .rst, .ce, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .tx_in_valid, .tx_in_ready, .tx_in_data, .tx_out_valid,
    .tx_out_ready, .tx_out_data, .rx_in_valid, .rx_in_ready, .rx_in_data, .rx_out_valid,
    .rx_out_ready, .rx_out_data, .core_sout, .core_sir_out_n, .sout, .sir_out_n, .rts_n,
    .loop_rts, .loop_break, .ctrl_rst);
  ufl_modem u_modem (.clk, .rst, .drain_en, .send, .send_data, .rts_n, .tx_out_valid,
    .tx_out_data, .tx_out_ready, .rx_in_ready, .rx_in_valid, .rx_in_data);

  always #25 clk = ~clk;

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  // Trigger levels for a four-entry receive FIFO
  function automatic logic [31:0] thr(input logic [1:0] cd);
    return cd[1] ? 32'h2 : 32'h1;
  endfunction : thr

  // Core bits wander at random so a forced pin level is really forced
  always @(posedge clk) begin
    r_q <= lfsr(r_q);
    core_sout <= r_q[0];
    core_sir_out_n <= r_q[1];
  end

  task complete_run();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : complete_run

  task chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task tick(input int m);
    repeat (m) @(negedge clk);
  endtask : tick

  // Request holds until the edge that samples ack; data is taken at that edge
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    int j;
    logic got;
    got = 1'b0;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    for (j = 0; j < 20 && !got; j++) begin
      @(posedge clk);
      got = (wb_ack_o === 1'b1);
    end
    if (!got) begin
      err_total++;
      complete_run();
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : bus

  task wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task chk_rd(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask : chk_rd

  task push(output logic acc);
    @(posedge clk);
    tx_in_valid <= 1'b1;
    tx_in_data <= r_q;
    pd = r_q;
    @(negedge clk);
    acc = tx_in_ready;
    @(posedge clk);
    tx_in_valid <= 1'b0;
  endtask : push

  task send_byte();
    @(posedge clk);
    send <= 1'b1;
    send_data <= r_q;
    @(posedge clk);
    send <= 1'b0;
    tick(5);
  endtask : send_byte

  initial begin
    al = '{ufl_pkg::ADDR_TX_LEVEL, ufl_pkg::ADDR_RX_LEVEL, ufl_pkg::ADDR_SOFT_RST,
      ufl_pkg::ADDR_RTS_ALIAS, ufl_pkg::ADDR_BRK_ALIAS, 32'h5000_10fc};
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 6; i++) chk_rd(al[i], 32'h0);
    n = 0;
    for (i = 0; i < 6; i++) begin
      push(ok);
      n += int'(ok);
    end
    chk(n, 4);
    chk_rd(ufl_pkg::ADDR_TX_LEVEL, 32'h4);
    wr(ufl_pkg::ADDR_SOFT_RST, 32'hfff4);
    chk_rd(ufl_pkg::ADDR_TX_LEVEL, 32'h0);
    chk_rd(ufl_pkg::ADDR_SOFT_RST, 32'h0);
    push(ok);
    chk_rd(ufl_pkg::ADDR_TX_LEVEL, 32'h1);
    chk(tx_out_data, pd);
    // Clock enable low must freeze the FIFO although the drain side is ready
    @(posedge clk);
    ce <= 1'b0;
    drain_en <= 1'b1;
    tick(3);
    @(posedge clk);
    ce <= 1'b1;
    drain_en <= 1'b0;
    chk_rd(ufl_pkg::ADDR_TX_LEVEL, 32'h1);
    @(posedge clk);
    drain_en <= 1'b1;
    tick(4);
    chk_rd(ufl_pkg::ADDR_TX_LEVEL, 32'h0);
    @(posedge clk);
    drain_en <= 1'b0;
    wr(ufl_pkg::ADDR_RTS_ALIAS, 32'hffff);
    chk_rd(ufl_pkg::ADDR_RTS_ALIAS, 32'h1);
    chk_rd(ufl_pkg::ADDR_MODEM_CTRL, 32'h2);
    chk(rts_n, 1'b0);
    wr(ufl_pkg::ADDR_MODEM_CTRL, 32'h0);
    chk_rd(ufl_pkg::ADDR_RTS_ALIAS, 32'h0);
    chk(rts_n, 1'b1);
    wr(ufl_pkg::ADDR_MODEM_CTRL, 32'h2);
    for (i = 0; i < 3; i++) send_byte();
    chk_rd(ufl_pkg::ADDR_RX_LEVEL, 32'h3);
    @(posedge clk);
    rx_out_ready <= 1'b1;
    tick(6);
    @(posedge clk);
    rx_out_ready <= 1'b0;
    chk_rd(ufl_pkg::ADDR_RX_LEVEL, 32'h0);
    for (i = 0; i < 2; i++) send_byte();
    wr(ufl_pkg::ADDR_SOFT_RST, 32'h2);
    chk_rd(ufl_pkg::ADDR_RX_LEVEL, 32'h0);
    for (c = 0; c < 4; c++) begin
      wr(ufl_pkg::ADDR_FIFO_CTRL, {24'h0, c[1:0], 6'h01});
      wr(ufl_pkg::ADDR_MODEM_CTRL, 32'h22);
      for (k = 1; k <= thr(c[1:0]); k++) begin
        send_byte();
        chk(rts_n, k >= thr(c[1:0]));
      end
      wr(ufl_pkg::ADDR_MODEM_CTRL, 32'h2);
      tick(2);
      chk(rts_n, 1'b0);
      wr(ufl_pkg::ADDR_SOFT_RST, 32'h2);
    end
    wr(ufl_pkg::ADDR_BRK_ALIAS, 32'hffff);
    chk_rd(ufl_pkg::ADDR_LINE_CTRL, 32'h40);
    chk_rd(ufl_pkg::ADDR_BRK_ALIAS, 32'h1);
    for (i = 0; i < 8; i++) begin
      tick(1);
      chk(sout, 1'b0);
    end
    wr(ufl_pkg::ADDR_MODEM_CTRL, 32'h40);
    n = 0;
    // Two whole pulse periods hold six low cycles whatever the phase
    for (i = 0; i < 64; i++) begin
      tick(1);
      n += int'(sir_out_n === 1'b0);
    end
    chk(n, 6);
    wr(ufl_pkg::ADDR_MODEM_CTRL, 32'h12);
    tick(2);
    chk({sout, rts_n, loop_rts, loop_break}, 4'hf);
    wr(ufl_pkg::ADDR_LINE_CTRL, 32'h0);
    chk_rd(ufl_pkg::ADDR_BRK_ALIAS, 32'h0);
    chk(loop_break, 1'b0);
    wr(ufl_pkg::ADDR_MODEM_CTRL, 32'h2);
    push(ok);
    wr(ufl_pkg::ADDR_SOFT_RST, 32'h1);
    tick(1);
    chk(ctrl_rst, 1'b1);
    for (i = 0; i < 10 && ctrl_rst !== 1'b0; i++) tick(1);
    if (ctrl_rst !== 1'b0) begin
      err_total++;
      complete_run();
    end
    chk_rd(ufl_pkg::ADDR_RTS_ALIAS, 32'h0);
    chk_rd(ufl_pkg::ADDR_TX_LEVEL, 32'h0);
    chk(rts_n, 1'b1);
    complete_run();
  end
endmodule : uart_fifo_level_and_shadow_regs_tb
